// ### bench/ict_fetch_model.sv
/*
  Fetch side model: presents one instruction request and holds it
  until the timing block takes it. Assumes one clock shared with the block.
*/
`timescale 1ns/1ps

module ict_fetch_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire ict_pkg::ict_req_s nextReq,
  input wire logic busy,
  output logic start,
  output ict_pkg::ict_req_s req
);
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      start <= 1'b0;
      req <= '0;
    end
    else if (go)
    begin
      start <= 1'b1;
      req <= nextReq;
    end
    else if (start && !busy)
    begin
      start <= 1'b0;
      // Scrambled once taken, so a stale copy cannot pass as valid
      req <= ~req;
    end
  end
endmodule

// ### bench/ict_timer_tb.sv
/*
  Testbench for the instruction cycle timing block: each scenario issues
  instructions through the fetch model and times busy and done.
  Assumes the package, the block and the fetch model are compiled first.
*/
`timescale 1ns/1ps

module ict_timer_tb;
  logic clk;
  logic reset;
  logic go;
  logic start;
  logic busy;
  logic done;
  logic branchTaken;
  logic unsupported;
  logic [ict_pkg::CNT_W-1:0] cycleTotal;
  ict_pkg::ict_req_s nextReq;
  ict_pkg::ict_req_s req;
  int failCount;
  int checksDone;

  ict_fetch_model i_fetch (.clk(clk), .reset(reset), .go(go), .nextReq(nextReq),
    .busy(busy), .start(start), .req(req));
  ict_timer i_dut (.clk(clk), .reset(reset), .start(start), .req(req), .busy(busy),
    .done(done), .branchTaken(branchTaken), .unsupported(unsupported),
    .cycleTotal(cycleTotal));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic endOfTest();
    $display("Checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A bounded wait ran out: count it and close the run
  task automatic timeout(input string what);
    failCount++;
    $display("Error %s expected 1 seen 0", what);
    endOfTest();
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      failCount++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic ict_pkg::ict_req_s mk(input ict_pkg::ict_op_e op, input logic f,
    input logic nb, input logic wd, input logic [15:0] n);
    ict_pkg::ict_req_s r;
    r = '0;
    r.op = op;
    r.flagSign = f;
    r.flagZero = f;
    r.flagOverflow = f;
    r.flagParity = f;
    r.countNonzero = 1'b1;
    r.narrowBus = nb;
    r.wordOp = wd;
    r.repCount = n;
    return r;
  endfunction

  task automatic launch(input ict_pkg::ict_req_s r);
    @(posedge clk);
    nextReq <= r;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask

  // Waits out the idle gap, then counts busy cycles up to done
  task automatic measure(input int exp, input logic tk);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (busy !== 1'b1)
    begin
      timeout("busy");
    end
    n = 1;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (done !== 1'b1)
    begin
      timeout("done");
    end
    check("cycles", n, exp);
    check("cycleTotal", {10'h000, cycleTotal}, exp);
    check("branchTaken", branchTaken, tk);
    @(posedge clk);
    #1;
    check("busyAfterDone", busy, 1'b0);
  endtask

  task automatic run(input ict_pkg::ict_req_s r, input int exp, input logic tk);
    launch(r);
    measure(exp, tk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_jumps();
    logic tk;
    for (int i = 0; i < 6; i++)
    begin
      for (int f = 0; f < 2; f++)
      begin
        tk = (i < 2) ? (f == 0) : (f == 1);
        run(mk(ict_pkg::ict_op_e'(i), f[0], f[0], 1'b0, 16'h0000), tk ? 5 : 3, tk);
      end
    end
    $display("test_jumps finished");
  endtask

  task automatic test_loops();
    logic tk;
    ict_pkg::ict_req_s r;
    for (int i = 6; i < 11; i++)
    begin
      for (int f = 0; f < 2; f++)
      begin
        tk = (i == 6) ? 1'b1 : ((i == 7 || i == 9) ? f[0] : !f[0]);
        run(mk(ict_pkg::ict_op_e'(i), f[0], f[0], 1'b0, 16'h0000), tk ? 4 : 3, tk);
      end
    end
    r = mk(ict_pkg::OP_LOOP, 1'b0, 1'b0, 1'b0, 16'h0000);
    r.countNonzero = 1'b0;
    run(r, 3, 1'b0);
    $display("test_loops finished");
  endtask

  task automatic test_strings();
    for (int n = 0; n < 6; n += 5)
    begin
      for (int b = 0; b < 2; b++)
      begin
        run(mk(ict_pkg::OP_LOAD_STRING_REP, 1'b0, b[0], 1'b1, n[15:0]),
          (b ? 12 : 8) * (n + 1), 1'b0);
        run(mk(ict_pkg::OP_MOVE_STRING_REP, 1'b0, b[0], 1'b1, n[15:0]),
          (b ? 32 : 24) * (n + 1), 1'b0);
      end
    end
    $display("test_strings finished");
  endtask

  task automatic test_moves();
    int e;
    for (int b = 0; b < 2; b++)
    begin
      for (int w = 0; w < 2; w++)
      begin
        e = b ? (w ? 12 : 8) : 5;
        run(mk(ict_pkg::OP_MOVE_VALUE_ACC_TO_MEM, 1'b0, b[0], w[0], 16'h0000), e, 1'b0);
        run(mk(ict_pkg::OP_MOVE_VALUE_MEM_TO_ACC, 1'b0, b[0], w[0], 16'h0000), e, 1'b0);
        run(mk(ict_pkg::OP_MOVE_VALUE_SEG_TO_REG, 1'b0, b[0], w[0], 16'h0000), 2, 1'b0);
        run(mk(ict_pkg::OP_MOVE_VALUE_SEG_TO_MEM, 1'b0, b[0], w[0], 16'h0000),
          b ? 20 : 5, 1'b0);
      end
    end
    $display("test_moves finished");
  endtask

  // Second request raised while busy must wait for the idle cycle
  task automatic test_single_and_refused();
    int n;
    run(mk(ict_pkg::OP_MOVE_VALUE_IMM_TO_REG, 1'b1, 1'b1, 1'b1, 16'hFFFF), 1, 1'b0);
    run(mk(ict_pkg::OP_OR_IMM_TO_ACC, 1'b1, 1'b1, 1'b1, 16'hFFFF), 1, 1'b0);
    launch(mk(ict_pkg::OP_JUMP_IF_ZERO, 1'b1, 1'b0, 1'b0, 16'h0000));
    launch(mk(ict_pkg::OP_OR_IMM_TO_ACC, 1'b0, 1'b0, 1'b0, 16'h0000));
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (done !== 1'b1)
    begin
      timeout("refusedDone");
    end
    check("refusedTotal", {10'h000, cycleTotal}, 5);
    @(posedge clk);
    #1;
    check("idleGap", busy, 1'b0);
    measure(1, 1'b0);
    $display("test_single_and_refused finished");
  endtask

  // Undecoded codes cost one cycle; reset mid-instruction clears all
  task automatic test_unsupported_and_reset();
    run(mk(ict_pkg::ict_op_e'(5'h13), 1'b1, 1'b1, 1'b1, 16'h0005), 1, 1'b0);
    check("unsupported", unsupported, 1'b1);
    run(mk(ict_pkg::OP_LOOP, 1'b0, 1'b0, 1'b0, 16'h0000), 4, 1'b1);
    check("unsupportedClear", unsupported, 1'b0);
    launch(mk(ict_pkg::OP_MOVE_STRING_REP, 1'b0, 1'b0, 1'b1, 16'h0005));
    repeat (3) @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    #1;
    check("resetOutputs", {6'h00, busy, done, branchTaken, unsupported, cycleTotal}, 0);
    @(posedge clk);
    reset <= 1'b0;
    run(mk(ict_pkg::OP_JUMP_IF_ZERO, 1'b1, 1'b1, 1'b0, 16'h0000), 5, 1'b1);
    $display("test_unsupported_and_reset finished");
  endtask

  initial
  begin
    failCount = 0;
    checksDone = 0;
    reset = 1'b1;
    go = 1'b0;
    nextReq = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check("idleOutputs", {6'h00, busy, done, branchTaken, unsupported, cycleTotal}, 0);
    test_jumps();
    test_loops();
    test_strings();
    test_moves();
    test_single_and_refused();
    test_unsupported_and_reset();
    endOfTest();
  end
endmodule

// ### logic/ict_pkg.sv
/*
  Package for the instruction cycle timing block: operation codes, the
  request carrier, the state layout and every cycle count.
  Assumes one processor clock and zero-wait-state memory.
*/
package ict_pkg;

  localparam int REP_W = 16;
  localparam int CNT_W = 22;
  localparam int BASE_W = 6;

  // ****************************************************************
  // Cycle counts
  // ****************************************************************
  localparam logic [BASE_W-1:0] CYC_JUMP_NOT_TAKEN = 6'h03;
  localparam logic [BASE_W-1:0] CYC_JUMP_TAKEN = 6'h05;
  localparam logic [BASE_W-1:0] CYC_LOOP_NOT_TAKEN = 6'h03;
  localparam logic [BASE_W-1:0] CYC_LOOP_TAKEN = 6'h04;
  localparam logic [BASE_W-1:0] CYC_LOAD_STRING_WIDE = 6'h08;
  localparam logic [BASE_W-1:0] CYC_LOAD_STRING_NARROW = 6'h0C;
  localparam logic [BASE_W-1:0] CYC_MOVE_STRING_WIDE = 6'h18;
  localparam logic [BASE_W-1:0] CYC_MOVE_STRING_NARROW = 6'h20;
  localparam logic [BASE_W-1:0] CYC_ACC_MEM_WIDE = 6'h05;
  localparam logic [BASE_W-1:0] CYC_ACC_MEM_NARROW_BYTE = 6'h08;
  localparam logic [BASE_W-1:0] CYC_ACC_MEM_NARROW_WORD = 6'h0C;
  localparam logic [BASE_W-1:0] CYC_IMM_TO_REG = 6'h01;
  localparam logic [BASE_W-1:0] CYC_OR_IMM_TO_ACC = 6'h01;
  localparam logic [BASE_W-1:0] CYC_SEG_TO_REG = 6'h02;
  localparam logic [BASE_W-1:0] CYC_SEG_TO_MEM_WIDE = 6'h05;
  localparam logic [BASE_W-1:0] CYC_SEG_TO_MEM_NARROW = 6'h14;
  localparam logic [BASE_W-1:0] CYC_UNSUPPORTED = 6'h01;

  // ****************************************************************
  // Operations
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_JUMP_IF_SIGN_CLEAR,
    OP_JUMP_IF_NONZERO,
    OP_JUMP_IF_OVERFLOW,
    OP_JUMP_IF_PARITY,
    OP_JUMP_IF_SIGN,
    OP_JUMP_IF_ZERO,
    OP_LOOP,
    OP_LOOP_WHILE_EQUAL,
    OP_LOOP_WHILE_NOT_EQUAL,
    OP_LOOP_WHILE_ZERO,
    OP_LOOP_WHILE_NOT_ZERO,
    OP_LOAD_STRING_REP,
    OP_MOVE_STRING_REP,
    OP_MOVE_VALUE_ACC_TO_MEM,
    OP_MOVE_VALUE_MEM_TO_ACC,
    OP_MOVE_VALUE_IMM_TO_REG,
    OP_OR_IMM_TO_ACC,
    OP_MOVE_VALUE_SEG_TO_REG,
    OP_MOVE_VALUE_SEG_TO_MEM
  } ict_op_e;

  typedef struct packed {
    ict_op_e op;
    logic flagSign;
    logic flagZero;
    logic flagOverflow;
    logic flagParity;
    logic countNonzero;
    logic narrowBus;
    logic wordOp;
    logic [REP_W-1:0] repCount;
  } ict_req_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic taken;
    logic unsupported;
    logic [CNT_W-1:0] remain;
    logic [CNT_W-1:0] cycles;
  } ict_state_s;

endpackage

// ### logic/ict_timer.sv
/*
  Instruction cycle timing engine: takes one instruction request, works
  out its execution time in clock cycles and holds busy for that long.
  Assumes start and the request come from logic on the same clock.
*/
`timescale 1ns/1ps

// How it works
// - Flag jumps: 3 not taken, 5 taken
// - Loops: 3 not taken, 4 taken
// - Repeated load string: 8+8n or 12+12n
// - Repeated move string: 24+24n or 32+32n
// - Accumulator to memory: 5, else 8/12
// - Memory to accumulator: 5, else 8/12
// - Immediate to register: one cycle
// - OR immediate into accumulator: one cycle
// - Segment move: 2 register, 5/20 memory
module ict_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire ict_pkg::ict_req_s req,
  output logic busy,
  output logic done,
  output logic branchTaken,
  output logic unsupported,
  output logic [ict_pkg::CNT_W-1:0] cycleTotal
);

  ict_pkg::ict_state_s st_ff;
  ict_pkg::ict_state_s nxt_st;
  logic [ict_pkg::BASE_W-1:0] base;
  logic [ict_pkg::CNT_W-1:0] total;
  logic isTaken;
  logic isBad;
  logic isRep;
  logic take;

  assign take = start && !st_ff.busy;

  // ****************************************************************
  // Cycle count lookup
  // ****************************************************************
  always_comb
  begin
    base = ict_pkg::CYC_UNSUPPORTED;
    isTaken = 1'b0;
    isBad = 1'b0;
    isRep = 1'b0;
    case (req.op)
      ict_pkg::OP_JUMP_IF_SIGN_CLEAR: isTaken = !req.flagSign;
      ict_pkg::OP_JUMP_IF_NONZERO: isTaken = !req.flagZero;
      ict_pkg::OP_JUMP_IF_OVERFLOW: isTaken = req.flagOverflow;
      ict_pkg::OP_JUMP_IF_PARITY: isTaken = req.flagParity;
      ict_pkg::OP_JUMP_IF_SIGN: isTaken = req.flagSign;
      ict_pkg::OP_JUMP_IF_ZERO: isTaken = req.flagZero;
      ict_pkg::OP_LOOP: isTaken = req.countNonzero;
      ict_pkg::OP_LOOP_WHILE_EQUAL,
      ict_pkg::OP_LOOP_WHILE_ZERO: isTaken = req.countNonzero && req.flagZero;
      ict_pkg::OP_LOOP_WHILE_NOT_EQUAL,
      ict_pkg::OP_LOOP_WHILE_NOT_ZERO: isTaken = req.countNonzero && !req.flagZero;
      default: isTaken = 1'b0;
    endcase
    case (req.op)
      ict_pkg::OP_JUMP_IF_SIGN_CLEAR,
      ict_pkg::OP_JUMP_IF_NONZERO,
      ict_pkg::OP_JUMP_IF_OVERFLOW,
      ict_pkg::OP_JUMP_IF_PARITY,
      ict_pkg::OP_JUMP_IF_SIGN,
      ict_pkg::OP_JUMP_IF_ZERO:
        base = isTaken ? ict_pkg::CYC_JUMP_TAKEN : ict_pkg::CYC_JUMP_NOT_TAKEN;
      ict_pkg::OP_LOOP,
      ict_pkg::OP_LOOP_WHILE_EQUAL,
      ict_pkg::OP_LOOP_WHILE_NOT_EQUAL,
      ict_pkg::OP_LOOP_WHILE_ZERO,
      ict_pkg::OP_LOOP_WHILE_NOT_ZERO:
        base = isTaken ? ict_pkg::CYC_LOOP_TAKEN : ict_pkg::CYC_LOOP_NOT_TAKEN;
      ict_pkg::OP_LOAD_STRING_REP:
      begin
        isRep = 1'b1;
        base = req.narrowBus ? ict_pkg::CYC_LOAD_STRING_NARROW
                             : ict_pkg::CYC_LOAD_STRING_WIDE;
      end
      ict_pkg::OP_MOVE_STRING_REP:
      begin
        isRep = 1'b1;
        base = req.narrowBus ? ict_pkg::CYC_MOVE_STRING_NARROW
                             : ict_pkg::CYC_MOVE_STRING_WIDE;
      end
      ict_pkg::OP_MOVE_VALUE_ACC_TO_MEM,
      ict_pkg::OP_MOVE_VALUE_MEM_TO_ACC:
        // Narrow bus needs a second byte transfer for words
        base = !req.narrowBus ? ict_pkg::CYC_ACC_MEM_WIDE
             : req.wordOp ? ict_pkg::CYC_ACC_MEM_NARROW_WORD
             : ict_pkg::CYC_ACC_MEM_NARROW_BYTE;
      ict_pkg::OP_MOVE_VALUE_IMM_TO_REG: base = ict_pkg::CYC_IMM_TO_REG;
      ict_pkg::OP_OR_IMM_TO_ACC: base = ict_pkg::CYC_OR_IMM_TO_ACC;
      ict_pkg::OP_MOVE_VALUE_SEG_TO_REG: base = ict_pkg::CYC_SEG_TO_REG;
      ict_pkg::OP_MOVE_VALUE_SEG_TO_MEM:
        base = req.narrowBus ? ict_pkg::CYC_SEG_TO_MEM_NARROW
                             : ict_pkg::CYC_SEG_TO_MEM_WIDE;
      default: isBad = 1'b1;
    endcase
    // Repeat cost grows linearly; width holds the largest count
    total = CNT_W_EXT(base);
    if (isRep)
    begin
      total = CNT_W_EXT(base) + CNT_W_EXT(base) * ict_pkg::CNT_W'(req.repCount);
    end
  end

  function automatic logic [ict_pkg::CNT_W-1:0] CNT_W_EXT(input logic [ict_pkg::BASE_W-1:0] v);
    CNT_W_EXT = {{(ict_pkg::CNT_W-ict_pkg::BASE_W){1'b0}}, v};
  endfunction

  // ****************************************************************
  // Execution counter
  // ****************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (!st_ff.busy)
    begin
      if (take)
      begin
        // Busy covers exactly total cycles, done marks the last
        nxt_st.busy = 1'b1;
        nxt_st.remain = total - 1'b1;
        nxt_st.done = (total == ict_pkg::CNT_W'(1));
        nxt_st.cycles = total;
        nxt_st.taken = isTaken;
        nxt_st.unsupported = isBad;
      end
    end
    else if (st_ff.remain == '0)
    begin
      nxt_st.busy = 1'b0;
    end
    else
    begin
      nxt_st.remain = st_ff.remain - 1'b1;
      nxt_st.done = (st_ff.remain == ict_pkg::CNT_W'(1));
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign done = st_ff.done;
  assign branchTaken = st_ff.taken;
  assign unsupported = st_ff.unsupported;
  assign cycleTotal = st_ff.cycles;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_jump_not_taken: assert property (@(posedge clk) disable iff (reset)
    take && req.op inside {ict_pkg::OP_JUMP_IF_SIGN_CLEAR, ict_pkg::OP_JUMP_IF_ZERO,
      ict_pkg::OP_JUMP_IF_NONZERO, ict_pkg::OP_JUMP_IF_OVERFLOW,
      ict_pkg::OP_JUMP_IF_PARITY, ict_pkg::OP_JUMP_IF_SIGN} && !isTaken
    |=> (busy && !done)[*2] ##1 done ##1 !busy)
    else $error("jump not taken not three cycles");

  chk_jump_taken: assert property (@(posedge clk) disable iff (reset)
    take && req.op == ict_pkg::OP_JUMP_IF_ZERO && req.flagZero
    |=> (busy && !done)[*4] ##1 done ##1 !busy)
    else $error("jump taken not five cycles");

  chk_loop_cycles: assert property (@(posedge clk) disable iff (reset)
    take && req.op == ict_pkg::OP_LOOP
    |=> cycleTotal == ($past(req.countNonzero) ? 22'h000004 : 22'h000003))
    else $error("loop cycle count wrong");

  chk_loop_done: assert property (@(posedge clk) disable iff (reset)
    take && req.op == ict_pkg::OP_LOOP && req.countNonzero |-> ##4 done)
    else $error("taken loop not done at four");

  chk_load_string: assert property (@(posedge clk) disable iff (reset)
    take && req.op == ict_pkg::OP_LOAD_STRING_REP
    |=> cycleTotal == ($past(req.narrowBus) ? 22'h00000C + 22'h00000C * $past(req.repCount)
                                            : 22'h000008 + 22'h000008 * $past(req.repCount)))
    else $error("load string count wrong");

  chk_move_string: assert property (@(posedge clk) disable iff (reset)
    take && req.op == ict_pkg::OP_MOVE_STRING_REP
    |=> cycleTotal == ($past(req.narrowBus) ? 22'h000020 + 22'h000020 * $past(req.repCount)
                                            : 22'h000018 + 22'h000018 * $past(req.repCount)))
    else $error("move string count wrong");

  chk_acc_store: assert property (@(posedge clk) disable iff (reset)
    take && req.op == ict_pkg::OP_MOVE_VALUE_ACC_TO_MEM && req.narrowBus && req.wordOp
    |-> ##12 done)
    else $error("narrow word store not twelve cycles");

  chk_acc_load: assert property (@(posedge clk) disable iff (reset)
    take && req.op == ict_pkg::OP_MOVE_VALUE_MEM_TO_ACC
    |=> cycleTotal == (!$past(req.narrowBus) ? 22'h000005 :
                       $past(req.wordOp) ? 22'h00000C : 22'h000008))
    else $error("accumulator load count wrong");

  chk_single_cycle: assert property (@(posedge clk) disable iff (reset)
    take && req.op inside {ict_pkg::OP_MOVE_VALUE_IMM_TO_REG, ict_pkg::OP_OR_IMM_TO_ACC}
    |=> busy && done ##1 !busy)
    else $error("single cycle op not one cycle");

  chk_segment_move: assert property (@(posedge clk) disable iff (reset)
    take && req.op == ict_pkg::OP_MOVE_VALUE_SEG_TO_MEM && req.narrowBus
    |=> cycleTotal == 22'h000014 ##19 done)
    else $error("segment store not twenty cycles");

  chk_done_ends: assert property (@(posedge clk) disable iff (reset)
    done |-> busy ##1 !busy && !done)
    else $error("done not on last busy cycle");

endmodule
